// ==== mrie_cfg.svh ====
// Constants for the move-and-return execution block.
// Assumes 14-bit instruction words and a 13-bit program counter.
`ifndef MRIE_CFG_SVH
`define MRIE_CFG_SVH
`define MRIE_PC_W 13
`define MRIE_FADDR_W 7
`define MRIE_STACK_DEPTH 8
`define MRIE_PC_RESET 13'h0000
`define MRIE_W_RESET 8'h00
`define MRIE_INT_EN_BIT 7
`define MRIE_CTRL_RESET 8'h00
`define MRIE_OP_NOP 14'h0000
`define MRIE_OP_IRET 14'h0009
`define MRIE_OP_LRET_HI 4'hd
`define MRIE_OP_LLIT_HI 4'hc
`define MRIE_OP_CWF_HI 7'h01
`define MRIE_MULTI_CYCLES 2
`endif

// ==== mrie_pkg.sv ====
// Types shared by the move-and-return execution block.
// Assumes nothing beyond the constant header.
package mrie_pkg;
    typedef enum logic [2:0] {
        MRIE_OP_NONE = 3'b000,
        MRIE_OP_NOP = 3'b001,
        MRIE_OP_CWF = 3'b010,
        MRIE_OP_LLIT = 3'b011,
        MRIE_OP_IRET = 3'b100,
        MRIE_OP_LRET = 3'b101
    } mrie_op_t;
    typedef enum logic [0:0] {
        MRIE_ST_EXEC = 1'b0,
        MRIE_ST_FLUSH = 1'b1
    } mrie_state_t;
endpackage

// ==== mrie_stack.sv ====
// Hardware return stack, circular, registered read of the top entry.
// Assumes push and pop are never asked in the same cycle.
`timescale 1ns/10ps
`include "mrie_cfg.svh"
module mrie_stack #(
    parameter int DEPTH = `MRIE_STACK_DEPTH,
    parameter int WIDTH = `MRIE_PC_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] stack_top
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] ptr;
    logic [AW-1:0] next_ptr;
    logic [WIDTH-1:0] next_top;

    // Overflow wraps silently, as in the small cores this mimics
    always_comb begin
        next_ptr = ptr;
        next_top = stack_top;
        if (push) begin
            next_ptr = AW'(ptr + 1'b1);
            next_top = push_data;
        end else if (pop) begin
            next_ptr = AW'(ptr - 1'b1);
            next_top = mem[AW'(ptr - 1'b1)];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ptr <= '0;
            stack_top <= '0;
        end else begin
            ptr <= next_ptr;
            stack_top <= next_top;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[AW'(ptr + 1'b1)] <= push_data;
        end
    end
endmodule

// ==== mrie_core.sv ====
// Execution unit for copy, load-literal, no-op and the two returns.
// Assumes one instruction word offered per cycle with instr_valid and
// that the fetch side honours instr_ready; others are reported unknown.
// Operation
// - Copy-work-to-file writes the working value to file address f, 0..127, flags untouched.
// - Load-literal puts its 8-bit literal into the working register, flags untouched.
// - Load-literal is decoded on bits 13:10 alone and accepts any value in its don't-care bits.
// - Interrupt-return pops the stack and loads the old stack top into the PC.
// - Interrupt-return sets the global interrupt enable, bit 7 of the control register.
// - Interrupt-return is one word and takes two instruction cycles.
// - Literal-return loads its 8-bit literal into the working register.
// - Literal-return restores the PC from the stack top and pops that entry.
// - Literal-return is one word, two cycles, no flags changed.
`timescale 1ns/10ps
`include "mrie_cfg.svh"
module mrie_core #(
    parameter int PC_W = `MRIE_PC_W,
    parameter int DEPTH = `MRIE_STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    output logic instr_ready,
    input wire logic call_push,
    input wire logic [PC_W-1:0] call_ret_addr,
    output logic [PC_W-1:0] pc,
    output logic [7:0] work,
    output logic [7:0] interrupt_control_register,
    output logic global_interrupt_enable,
    output logic file_we,
    output logic [`MRIE_FADDR_W-1:0] file_addr,
    output logic [7:0] file_wdata,
    output logic flags_we,
    output logic instr_unknown,
    output mrie_pkg::mrie_op_t op_done
);
    import mrie_pkg::*;

    mrie_state_t state;
    mrie_state_t next_state;
    logic [PC_W-1:0] next_pc;
    logic [7:0] next_work;
    logic [7:0] next_ctrl;
    logic next_file_we;
    logic [`MRIE_FADDR_W-1:0] next_file_addr;
    logic [7:0] next_file_wdata;
    logic next_unknown;
    mrie_op_t next_op_done;
    mrie_op_t pend_op;
    mrie_op_t next_pend_op;
    logic pop;
    logic [PC_W-1:0] stack_top;
    mrie_op_t dec;
    logic take;

    function automatic mrie_op_t decode(input logic [13:0] w);
        mrie_op_t r;
        r = MRIE_OP_NONE;
        if (w == `MRIE_OP_NOP) begin
            r = MRIE_OP_NOP;
        end else if (w == `MRIE_OP_IRET) begin
            r = MRIE_OP_IRET;
        end else if (w[13:7] == `MRIE_OP_CWF_HI) begin
            r = MRIE_OP_CWF;
        end else if (w[13:10] == `MRIE_OP_LLIT_HI) begin
            r = MRIE_OP_LLIT;
        end else if (w[13:10] == `MRIE_OP_LRET_HI) begin
            r = MRIE_OP_LRET;
        end
        return r;
    endfunction

    // The PC wraps at the top of program memory
    function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] p);
        return PC_W'(p + 1'b1);
    endfunction

    // The literal is the low byte; the bits above it are don't-care
    function automatic logic [7:0] lit_of(input logic [13:0] w);
        return w[7:0];
    endfunction

    assign dec = decode(instr);
    // A word is taken only outside the flush cycle of a return
    assign take = instr_valid && instr_ready;
    assign global_interrupt_enable =
        interrupt_control_register[`MRIE_INT_EN_BIT];
    // Status flags are never written by this group of instructions
    assign flags_we = 1'b0;
    // Second cycle of a return is a flush: the fetched word is discarded
    assign instr_ready = (state == MRIE_ST_EXEC);

    // Calls push from outside the unit; only the two returns here pop
    mrie_stack #(
        .DEPTH(DEPTH),
        .WIDTH(PC_W)
    ) u_stack (
        .mclk(mclk),
        .arst_n(arst_n),
        .push(call_push),
        .push_data(call_ret_addr),
        .pop(pop),
        .stack_top(stack_top)
    );

    // Sequencing: a return holds the fetch side off for one flush cycle
    always_comb begin
        next_state = state;
        next_pend_op = pend_op;
        next_op_done = MRIE_OP_NONE;
        next_unknown = 1'b0;
        case (state)
            MRIE_ST_EXEC: begin
                if (take) begin
                    case (dec)
                        MRIE_OP_NOP, MRIE_OP_CWF, MRIE_OP_LLIT: begin
                            next_op_done = dec;
                        end
                        MRIE_OP_IRET, MRIE_OP_LRET: begin
                            next_pend_op = dec;
                            next_state = MRIE_ST_FLUSH;
                        end
                        default: begin
                            // Undecoded words are flagged, not trapped
                            next_unknown = 1'b1;
                        end
                    endcase
                end
            end
            MRIE_ST_FLUSH: begin
                next_op_done = pend_op;
                next_pend_op = MRIE_OP_NONE;
                next_state = MRIE_ST_EXEC;
            end
            default: begin
                next_state = MRIE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= MRIE_ST_EXEC;
            pend_op <= MRIE_OP_NONE;
            op_done <= MRIE_OP_NONE;
            instr_unknown <= 1'b0;
        end else begin
            state <= next_state;
            pend_op <= next_pend_op;
            op_done <= next_op_done;
            instr_unknown <= next_unknown;
        end
    end

    // Program flow and working state
    always_comb begin
        next_pc = pc;
        next_work = work;
        next_ctrl = interrupt_control_register;
        pop = 1'b0;
        if (take) begin
            case (dec)
                MRIE_OP_LLIT: begin
                    next_work = lit_of(instr);
                    next_pc = pc_step(pc);
                end
                MRIE_OP_IRET: begin
                    next_pc = stack_top;
                    pop = 1'b1;
                    next_ctrl[`MRIE_INT_EN_BIT] = 1'b1;
                end
                MRIE_OP_LRET: begin
                    next_work = lit_of(instr);
                    next_pc = stack_top;
                    pop = 1'b1;
                end
                default: begin
                    // No-op, copy and unknown words only step the PC
                    next_pc = pc_step(pc);
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pc <= `MRIE_PC_RESET;
            work <= `MRIE_W_RESET;
            interrupt_control_register <= `MRIE_CTRL_RESET;
        end else begin
            pc <= next_pc;
            work <= next_work;
            interrupt_control_register <= next_ctrl;
        end
    end

    // File write port; the address and data hold between writes
    always_comb begin
        next_file_we = 1'b0;
        next_file_addr = file_addr;
        next_file_wdata = file_wdata;
        if (take && dec == MRIE_OP_CWF) begin
            next_file_we = 1'b1;
            next_file_addr = instr[`MRIE_FADDR_W-1:0];
            next_file_wdata = work;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            file_we <= 1'b0;
            file_addr <= '0;
            file_wdata <= 8'h00;
        end else begin
            file_we <= next_file_we;
            file_addr <= next_file_addr;
            file_wdata <= next_file_wdata;
        end
    end
endmodule

// ==== mrie_core_assertions.sv ====
// Checker for the move-and-return execution unit.
// Sees only the ports of mrie_core and is bound to it at the foot.
`timescale 1ns/10ps
`include "mrie_cfg.svh"
module mrie_core_chk #(
    parameter int PC_W = 13,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic instr_ready,
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0] work,
    input wire logic [7:0] interrupt_control_register,
    input wire logic global_interrupt_enable,
    input wire logic file_we,
    input wire logic [`MRIE_FADDR_W-1:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic flags_we,
    input wire mrie_pkg::mrie_op_t op_done
);
    import mrie_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire take = instr_valid && instr_ready;
    wire cwf = instr[13:7] == 7'h01;
    wire llit = instr[13:10] == 4'hc;
    sequence s_ret_tail(mrie_op_t c);
        !instr_ready ##1 (instr_ready && op_done == c);
    endsequence
    a_cwf_write: assert property (take && cwf |=> file_we
        && file_addr == $past(instr[6:0]) && file_wdata == $past(work)
        && op_done == MRIE_OP_CWF) else $error("copy to file wrong");
    a_llit_load: assert property (take && llit |=>
        work == $past(instr[7:0]) && op_done == MRIE_OP_LLIT)
        else $error("literal load wrong");
    a_nop_step: assert property (take && instr == 14'h0000 |=>
        pc == PC_W'($past(pc) + 1) && $stable(work) && !file_we
        && op_done == MRIE_OP_NOP) else $error("no-op wrong");
    a_iret_seq: assert property (take && instr == 14'h0009 |=>
        global_interrupt_enable ##0 s_ret_tail(MRIE_OP_IRET))
        else $error("interrupt return wrong");
    a_lret_seq: assert property (take && instr[13:10] == 4'hd |=>
        work == $past(instr[7:0]) ##0 s_ret_tail(MRIE_OP_LRET))
        else $error("literal return wrong");
    a_one_cycle: assert property (take && (cwf || llit) |=>
        pc == PC_W'($past(pc) + 1) && instr_ready)
        else $error("single cycle op wrong");
    a_flush_refuse: assert property (!instr_ready |=>
        !file_we && $stable(work) && op_done inside {MRIE_OP_IRET, MRIE_OP_LRET})
        else $error("flush cycle not idle");
    a_flags_quiet: assert property (!flags_we
        && global_interrupt_enable == interrupt_control_register[7]
        && $stable(interrupt_control_register[6:0]))
        else $error("flags or enable bit wrong");
    a_enable_rise: assert property (
        $rose(global_interrupt_enable) |-> $past(take && instr == 14'h0009))
        else $error("enable bit rose without a return");
endmodule
bind mrie_core mrie_core_chk #(.PC_W(PC_W), .DEPTH(DEPTH)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .pc(pc), .work(work),
    .interrupt_control_register(interrupt_control_register),
    .global_interrupt_enable(global_interrupt_enable), .file_we(file_we),
    .file_addr(file_addr), .file_wdata(file_wdata), .flags_we(flags_we),
    .op_done(op_done));

// ==== mrie_core_bench.sv ====
// Self-checking bench for the move-and-return execution unit.
// Drives mrie_core directly; the checker is bound in its own file.
`timescale 1ns/10ps
`include "mrie_cfg.svh"
module mrie_core_bench;
    import mrie_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, call_push = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [12:0] call_ret_addr = 13'h0000, pc, p;
    logic [7:0] work, ctrl, file_wdata;
    logic [6:0] file_addr;
    logic instr_ready, int_en, file_we, flags_we, unknown;
    mrie_op_t op_done;
    int fail_count = 0, check_count = 0;
    // Rows: instruction word, completion code, working value after
    logic [24:0] rows [7] = '{{14'h305a, 3'h3, 8'h5a}, {14'h30ff, 3'h3, 8'hff},
        {14'h00ff, 3'h2, 8'hff}, {14'h0000, 3'h1, 8'hff},
        {14'h3000, 3'h3, 8'h00}, {14'h0080, 3'h2, 8'h00},
        {14'h0001, 3'h0, 8'h00}};
    mrie_core u_dut (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .call_push(call_push),
        .call_ret_addr(call_ret_addr), .pc(pc), .work(work),
        .interrupt_control_register(ctrl), .global_interrupt_enable(int_en),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
        .flags_we(flags_we), .instr_unknown(unknown), .op_done(op_done));
    initial forever #20 mclk = ~mclk;
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic go(input logic [13:0] w);
        @(posedge mclk);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
    endtask
    // A literal load is kept offered in the flush cycle; it must be ignored
    task automatic ret(input logic [13:0] w, input logic [12:0] ep,
                       input logic [7:0] ew, input logic [2:0] eo);
        @(posedge mclk);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr <= 14'h3011;
        @(negedge mclk);
        chk(pc, ep);
        chk(instr_ready, 1'b0);
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
        chk(op_done, eo);
        chk(work, ew);
        chk(instr_ready, 1'b1);
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        chk({pc, work}, 21'h0);
        chk({ctrl, int_en, instr_ready}, 10'h001);
        arst_n <= 1'b1;
        @(negedge mclk);
        p = pc;
        foreach (rows[i]) begin
            go(rows[i][24:11]);
            chk(op_done, rows[i][10:8]);
            chk(work, rows[i][7:0]);
            chk(pc, p + 13'h1);
            chk(file_we, rows[i][10:8] == 3'h2);
            chk(flags_we, 1'b0);
            chk(unknown, rows[i][10:8] == 3'h0);
            if (rows[i][10:8] == 3'h2)
                chk({file_addr, file_wdata}, {rows[i][17:11], rows[i][7:0]});
            p = pc;
        end
        @(posedge mclk);
        call_ret_addr <= 13'h0123;
        call_push <= 1'b1;
        @(posedge mclk);
        call_ret_addr <= 13'h1abc;
        @(posedge mclk);
        call_push <= 1'b0;
        ret(14'h0009, 13'h1abc, 8'h00, 3'h4);
        chk({int_en, ctrl}, 9'h180);
        ret(14'h3477, 13'h0123, 8'h77, 3'h5);
        // Back to back, with the literal's free bits set
        @(posedge mclk);
        instr <= 14'h3342;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr <= 14'h0085;
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
        chk({file_addr, file_wdata}, {7'h05, 8'h42});
        chk(pc, 13'h0125);
        // Reset in mid-run, with the enable bit set, clears it all again
        @(posedge mclk);
        arst_n <= 1'b0;
        @(negedge mclk);
        chk({pc, work, op_done}, 24'h0);
        chk({ctrl, int_en, instr_ready, file_we, unknown}, 12'h004);
        @(posedge mclk);
        arst_n <= 1'b1;
        go(14'h3066);
        chk({pc, work}, {13'h0001, 8'h66});
        stop_test;
    end
endmodule
